/* design/decoder_pkg.sv */
package decoder_pkg;

  // ****************************************************************
  // Operation kinds and decode states
  // ****************************************************************
  // Seventeen kinds, so the code needs five bits
  typedef enum logic [4:0] {
    OP_NONE, OP_TEST_RM, OP_TEST_IMM_RM, OP_TEST_IMM_ACC, OP_OR, OP_XOR, OP_NOT,
    OP_STRING_COPY, OP_STRING_COMPARE, OP_STRING_SCAN, OP_STRING_LOAD,
    OP_STRING_SAVE, OP_STRING_INPUT, OP_STRING_OUTPUT, OP_CALL_NEAR_IND,
    OP_GRP_UNARY, OP_GRP_CALL
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PREFIXED, S_MODRM, S_DISP_LO, S_DISP_HI, S_IMM_LO, S_IMM_HI,
    S_START, S_EXEC, S_ELEM
  } state_t;

  // ****************************************************************
  // Opcode patterns (upper bits of the first byte)
  // ****************************************************************
  localparam logic [6:0] OPC_TEST_RM      = 7'h42;
  localparam logic [6:0] OPC_GROUP_UNARY  = 7'h7B;
  localparam logic [6:0] OPC_TEST_ACC     = 7'h54;
  localparam logic [5:0] OPC_OR_RM        = 6'h02;
  localparam logic [5:0] OPC_XOR_RM       = 6'h0C;
  localparam logic [6:0] OPC_STR_COPY     = 7'h52;
  localparam logic [6:0] OPC_STR_COMPARE  = 7'h53;
  localparam logic [6:0] OPC_STR_SCAN     = 7'h57;
  localparam logic [6:0] OPC_STR_LOAD     = 7'h56;
  localparam logic [6:0] OPC_STR_SAVE     = 7'h55;
  localparam logic [6:0] OPC_STR_INPUT    = 7'h36;
  localparam logic [6:0] OPC_STR_OUTPUT   = 7'h37;
  localparam logic [7:0] OPC_GROUP_CALL   = 8'hFF;
  localparam logic [7:0] OPC_ITERATE      = 8'hF2;
  localparam logic [6:0] OPC_ITERATE_Z    = 7'h79;

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int         OPC_W_BIT        = 0;
  localparam int         OPC_D_BIT        = 1;
  localparam int         PREFIX_Z_BIT     = 0;
  localparam logic [2:0] REG_TEST_IMM     = 3'h0;
  localparam logic [2:0] REG_INVERT       = 3'h2;
  localparam logic [2:0] REG_CALL_NEAR    = 3'h2;
  localparam logic [1:0] MOD_NO_DISP      = 2'h0;
  localparam logic [1:0] MOD_DISP8        = 2'h1;
  localparam logic [1:0] MOD_DISP16       = 2'h2;
  localparam logic [1:0] MOD_REGISTER     = 2'h3;
  localparam logic [2:0] RM_DIRECT        = 3'h6;

  // ****************************************************************
  // Cycle budgets
  // ****************************************************************
  localparam logic [7:0] CYC_LOGIC_REG    = 8'h03;
  localparam logic [7:0] CYC_LOGIC_MEM    = 8'h0A;
  localparam logic [7:0] CYC_TEST_IMM_REG = 8'h04;
  localparam logic [7:0] CYC_ACC_BYTE     = 8'h03;
  localparam logic [7:0] CYC_ACC_WORD     = 8'h04;
  localparam logic [7:0] CYC_COPY         = 8'h0E;
  localparam logic [7:0] CYC_COMPARE      = 8'h16;
  localparam logic [7:0] CYC_SCAN         = 8'h0F;
  localparam logic [7:0] CYC_LOAD         = 8'h0C;
  localparam logic [7:0] CYC_SAVE         = 8'h0A;
  localparam logic [7:0] CYC_PORT         = 8'h0E;
  localparam logic [7:0] CYC_CALL_REG     = 8'h11;
  localparam logic [7:0] CYC_CALL_MEM     = 8'h1B;
  localparam logic [7:0] REP_FIX_COPY     = 8'h08;
  localparam logic [7:0] REP_FIX_CMPSCAN  = 8'h05;
  localparam logic [7:0] REP_FIX_LDSV     = 8'h06;
  localparam logic [7:0] REP_FIX_PORT     = 8'h08;
  localparam logic [7:0] REP_PER_COPY     = 8'h08;
  localparam logic [7:0] REP_PER_LOAD     = 8'h0B;
  localparam logic [7:0] REP_PER_SAVE     = 8'h09;
  localparam logic [7:0] REP_PER_PORT     = 8'h08;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

endpackage

/* design/decode_link_if.sv */
// Carries modrm decode and cycle timer traffic inside the decoder
interface decode_link_if;
  logic [7:0] modrm;
  logic       is_reg;
  logic [1:0] disp_len;
  logic [2:0] reg_f;
  logic [2:0] rm_f;
  logic       load;
  logic [7:0] load_value;
  logic       expire;

  modport field_side (input modrm, output is_reg, disp_len, reg_f, rm_f);
  modport timer_side (input load, load_value, output expire);
  modport ctrl (output modrm, load, load_value,
                input is_reg, disp_len, reg_f, rm_f, expire);
endinterface

/* design/modrm_fields.sv */
module modrm_fields
  import decoder_pkg::*;
(
  decode_link_if.field_side link
);

  // ****************************************************************
  // Addressing kind decode
  // ****************************************************************
  wire [1:0] mod_f = link.modrm[7:6];

  assign link.reg_f  = link.modrm[5:3];
  assign link.rm_f   = link.modrm[2:0];
  assign link.is_reg = (mod_f == MOD_REGISTER);  // RULE15
  // One byte for short offsets, two for long or direct addressing
  assign link.disp_len = (mod_f == MOD_DISP8)  ? 2'd1 :  // RULE16
                         (mod_f == MOD_DISP16) ? 2'd2 :
                         (mod_f == MOD_NO_DISP && link.rm_f == RM_DIRECT) ? 2'd2 : 2'd0;

endmodule

/* design/cycle_timer.sv */
module cycle_timer
  import decoder_pkg::*;
(
  input  wire logic    i_mclk,
  input  wire logic    i_reset,
  decode_link_if.timer_side link
);

  logic [7:0] remaining;

  // ****************************************************************
  // Down counter; expires on its last cycle
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      remaining <= BYTE_RESET;
    end else if (link.load) begin
      remaining <= link.load_value;
    end else if (remaining != BYTE_RESET) begin
      remaining <= remaining - 8'd1;
    end
  end

  assign link.expire = (remaining == 8'd1);

endmodule

/* design/logic_string_call_decoder.sv */
// What this block does
// RULE1: Register test: flags only, 3 or 10
// RULE2: Immediate test on reg/mem: 4 or 10
// RULE3: Immediate test on accumulator: 3 or 4
// RULE4: Union and difference, either direction: 3/10
// RULE5: Invert register or memory in place: 3/10
// RULE6: Single string copy takes 14 cycles
// RULE7: Single string compare takes 22 cycles
// RULE8: Single string scan takes 15 cycles
// RULE9: Single string load takes 12 cycles
// RULE10: Single string save takes 10 cycles
// RULE11: String input from port pointer: 14
// RULE12: String output to port pointer: 14
// RULE13: Iterate prefix repeats by count register
// RULE14: Near indirect subroutine jump: 17 or 27
// RULE15: Addressing kind 11 names a register
// RULE16: Kind 01 takes sign-extended byte offset
// RULE17: Lowest opcode bit selects byte or word
// RULE18: Direction bit picks register as destination
module logic_string_call_decoder
  import decoder_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  input  wire logic [15:0] i_count_register,
  input  wire logic        i_zero_flag,
  output logic             o_byte_ready,
  output logic             o_busy,
  output decoder_pkg::op_t o_op,
  output logic             o_word,
  output logic             o_reg_is_dst,
  output logic             o_operand_is_reg,
  output logic [2:0]       o_reg_field,
  output logic [2:0]       o_rm_field,
  output logic [15:0]      o_disp,
  output logic [15:0]      o_imm,
  output logic             o_repeat,
  output logic [15:0]      o_count_left,
  output logic             o_element_strobe,
  output logic             o_done,
  output logic             o_unclaimed
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic op_t classify(input logic [7:0] b);
    if (b[7:1] == OPC_TEST_RM) return OP_TEST_RM;  // RULE1
    if (b[7:1] == OPC_TEST_ACC) return OP_TEST_IMM_ACC;  // RULE3
    if (b[7:2] == OPC_OR_RM) return OP_OR;  // RULE4
    if (b[7:2] == OPC_XOR_RM) return OP_XOR;  // RULE4
    if (b[7:1] == OPC_GROUP_UNARY) return OP_GRP_UNARY;
    if (b == OPC_GROUP_CALL) return OP_GRP_CALL;
    if (b[7:1] == OPC_STR_COPY) return OP_STRING_COPY;  // RULE6
    if (b[7:1] == OPC_STR_COMPARE) return OP_STRING_COMPARE;  // RULE7
    if (b[7:1] == OPC_STR_SCAN) return OP_STRING_SCAN;  // RULE8
    if (b[7:1] == OPC_STR_LOAD) return OP_STRING_LOAD;  // RULE9
    if (b[7:1] == OPC_STR_SAVE) return OP_STRING_SAVE;  // RULE10
    if (b[7:1] == OPC_STR_INPUT) return OP_STRING_INPUT;  // RULE11
    if (b[7:1] == OPC_STR_OUTPUT) return OP_STRING_OUTPUT;  // RULE12
    return OP_NONE;
  endfunction

  function automatic logic is_string(input op_t op);
    return op inside {OP_STRING_COPY, OP_STRING_COMPARE, OP_STRING_SCAN,
                      OP_STRING_LOAD, OP_STRING_SAVE, OP_STRING_INPUT, OP_STRING_OUTPUT};
  endfunction

  function automatic logic is_cmp_scan(input op_t op);
    return (op == OP_STRING_COMPARE) || (op == OP_STRING_SCAN);
  endfunction

  function automatic logic needs_imm(input op_t op);
    return (op == OP_TEST_IMM_RM) || (op == OP_TEST_IMM_ACC);
  endfunction

  // Single pass cost, register or memory form
  function automatic logic [7:0] exec_cost(input op_t op, input logic reg_form,
                                           input logic wide);
    case (op)
      OP_TEST_RM, OP_OR, OP_XOR, OP_NOT:
        return reg_form ? CYC_LOGIC_REG : CYC_LOGIC_MEM;  // RULE1 RULE4 RULE5
      OP_TEST_IMM_RM:    return reg_form ? CYC_TEST_IMM_REG : CYC_LOGIC_MEM;  // RULE2
      OP_TEST_IMM_ACC:   return wide ? CYC_ACC_WORD : CYC_ACC_BYTE;  // RULE3
      OP_STRING_COPY:    return CYC_COPY;  // RULE6
      OP_STRING_COMPARE: return CYC_COMPARE;  // RULE7
      OP_STRING_SCAN:    return CYC_SCAN;  // RULE8
      OP_STRING_LOAD:    return CYC_LOAD;  // RULE9
      OP_STRING_SAVE:    return CYC_SAVE;  // RULE10
      OP_STRING_INPUT, OP_STRING_OUTPUT: return CYC_PORT;  // RULE11 RULE12
      OP_CALL_NEAR_IND:  return reg_form ? CYC_CALL_REG : CYC_CALL_MEM;  // RULE14
      default:           return CYC_LOGIC_REG;
    endcase
  endfunction

  // Fixed part of a repeated string operation
  function automatic logic [7:0] rep_fixed(input op_t op);
    case (op)
      OP_STRING_COPY:                     return REP_FIX_COPY;
      OP_STRING_COMPARE, OP_STRING_SCAN:  return REP_FIX_CMPSCAN;
      OP_STRING_LOAD, OP_STRING_SAVE:     return REP_FIX_LDSV;
      default:                            return REP_FIX_PORT;
    endcase
  endfunction

  // Per element part of a repeated string operation
  function automatic logic [7:0] rep_per(input op_t op);
    case (op)
      OP_STRING_COPY:    return REP_PER_COPY;
      OP_STRING_COMPARE: return CYC_COMPARE;
      OP_STRING_SCAN:    return CYC_SCAN;
      OP_STRING_LOAD:    return REP_PER_LOAD;
      OP_STRING_SAVE:    return REP_PER_SAVE;
      default:           return REP_PER_PORT;
    endcase
  endfunction

  // ****************************************************************
  // State and working registers
  // ****************************************************************
  state_t      state;
  state_t      next_state;
  op_t         op;
  logic        word;
  logic        reg_is_dst;
  logic        is_reg;
  logic [2:0]  reg_field;
  logic [2:0]  rm_field;
  logic [1:0]  disp_len;
  logic [15:0] disp;
  logic [15:0] imm;
  logic        iterate_prefix;
  logic        rep_z;
  logic        rep_any;
  logic [15:0] count;
  logic        next_done;
  logic        next_unclaimed;
  logic        next_elem;

  decode_link_if link ();

  modrm_fields u_fields (
    .link (link.field_side)
  );

  cycle_timer u_timer (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .link    (link.timer_side)
  );

  // ****************************************************************
  // Combinational decode of the incoming byte
  // ****************************************************************
  wire  take       = i_byte_valid && o_byte_ready;
  wire  opc_state  = (state == S_IDLE) || (state == S_PREFIXED);
  op_t  new_op;
  op_t  resolved_op;
  assign new_op = classify(i_byte);
  wire  is_prefix  = (i_byte[7:1] == OPC_ITERATE_Z);
  // The z form only makes sense on compare and scan
  wire  rep_fits   = is_string(new_op) && (!rep_any || is_cmp_scan(new_op));  // RULE13
  wire  wide_new   = i_byte[OPC_W_BIT];  // RULE17
  // Group opcodes become real only once the reg field is seen
  assign resolved_op =
      (op == OP_GRP_UNARY && link.reg_f == REG_TEST_IMM) ? OP_TEST_IMM_RM :  // RULE2
      (op == OP_GRP_UNARY && link.reg_f == REG_INVERT)   ? OP_NOT :  // RULE5
      (op == OP_GRP_CALL && link.reg_f == REG_CALL_NEAR) ? OP_CALL_NEAR_IND :  // RULE14
      (op == OP_GRP_UNARY || op == OP_GRP_CALL)          ? OP_NONE : op;
  wire  after_disp = needs_imm(op) ? 1'b1 : 1'b0;
  // Compare and scan end early when the zero flag leaves the wanted sense
  wire  stop       = is_cmp_scan(op) && (i_zero_flag != rep_z);  // RULE13
  wire  last_elem  = (count == 16'd1) || stop;
  wire  more_elems = iterate_prefix && (count != WORD_RESET);

  assign link.modrm = i_byte;
  // Timer reloads at start, and at each element boundary
  assign link.load = (state == S_START) ||
                     (state == S_EXEC && link.expire && more_elems) ||
                     (state == S_ELEM && link.expire && !last_elem);
  assign link.load_value = (state == S_START && !iterate_prefix) ? exec_cost(op, is_reg, word) :
                           (state == S_START)         ? rep_fixed(op) : rep_per(op);  // RULE13

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state     = state;
    next_done      = 1'b0;
    next_unclaimed = 1'b0;
    next_elem      = 1'b0;
    unique case (state)
      S_IDLE, S_PREFIXED: begin
        if (take) begin
          if (state == S_IDLE && is_prefix) begin
            next_state = S_PREFIXED;  // RULE13
          end else if ((state == S_PREFIXED && !rep_fits) || new_op == OP_NONE) begin
            next_state     = S_IDLE;
            next_unclaimed = 1'b1;
          end else if (is_string(new_op)) begin
            next_state = S_START;
          end else if (new_op == OP_TEST_IMM_ACC) begin
            next_state = S_IMM_LO;  // RULE3
          end else begin
            next_state = S_MODRM;
          end
        end
      end
      S_MODRM: begin
        if (take) begin
          if (resolved_op == OP_NONE) begin
            next_state     = S_IDLE;
            next_unclaimed = 1'b1;
          end else if (link.disp_len != 2'd0) begin
            next_state = S_DISP_LO;
          end else if (needs_imm(resolved_op)) begin
            next_state = S_IMM_LO;
          end else begin
            next_state = S_START;
          end
        end
      end
      S_DISP_LO: begin
        if (take) begin
          next_state = (disp_len == 2'd2) ? S_DISP_HI : (after_disp ? S_IMM_LO : S_START);
        end
      end
      S_DISP_HI: begin
        if (take) begin
          next_state = after_disp ? S_IMM_LO : S_START;
        end
      end
      S_IMM_LO: begin
        if (take) begin
          next_state = word ? S_IMM_HI : S_START;  // RULE2 RULE3
        end
      end
      S_IMM_HI: begin
        if (take) begin
          next_state = S_START;
        end
      end
      S_START: begin
        next_state = S_EXEC;
      end
      S_EXEC: begin
        if (link.expire) begin
          next_state = more_elems ? S_ELEM : S_IDLE;  // RULE13
          next_done  = !more_elems;
        end
      end
      S_ELEM: begin
        if (link.expire) begin
          next_elem  = 1'b1;
          next_state = last_elem ? S_IDLE : S_ELEM;
          next_done  = last_elem;
        end
      end
    endcase
  end

  // ****************************************************************
  // Control flops
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state            <= S_IDLE;
      o_byte_ready     <= 1'b0;
      o_busy           <= 1'b0;
      o_done           <= 1'b0;
      o_unclaimed      <= 1'b0;
      o_element_strobe <= 1'b0;
    end else begin
      state            <= next_state;
      o_byte_ready     <= next_state inside {S_IDLE, S_PREFIXED, S_MODRM, S_DISP_LO,
                                             S_DISP_HI, S_IMM_LO, S_IMM_HI};
      o_busy           <= (next_state != S_IDLE);
      o_done           <= next_done;
      o_unclaimed      <= next_unclaimed;
      o_element_strobe <= next_elem;
    end
  end

  // ****************************************************************
  // Opcode and modrm capture
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      op         <= OP_NONE;
      word       <= 1'b0;
      reg_is_dst <= 1'b0;
      is_reg     <= 1'b0;
      reg_field  <= 3'h0;
      rm_field   <= 3'h0;
      disp_len   <= 2'd0;
      iterate_prefix        <= 1'b0;
      rep_z      <= 1'b0;
      rep_any    <= 1'b0;
    end else if (take && opc_state) begin
      op         <= new_op;
      word       <= wide_new;  // RULE17
      // Only union and difference carry a direction bit
      reg_is_dst <= (new_op == OP_OR || new_op == OP_XOR) && i_byte[OPC_D_BIT];  // RULE18
      is_reg     <= (new_op == OP_TEST_IMM_ACC);
      if (state == S_IDLE) begin
        iterate_prefix     <= is_prefix;
        rep_z   <= i_byte[PREFIX_Z_BIT];
        rep_any <= is_prefix && (i_byte != OPC_ITERATE);
      end
    end else if (take && state == S_MODRM) begin
      op        <= resolved_op;
      is_reg    <= link.is_reg;  // RULE15
      reg_field <= link.reg_f;
      rm_field  <= link.rm_f;
      disp_len  <= link.disp_len;
    end
  end

  // ****************************************************************
  // Offset, immediate and element count
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      disp <= WORD_RESET;
      imm  <= WORD_RESET;
    end else if (take && state == S_MODRM) begin
      disp <= WORD_RESET;
    end else if (take && state == S_DISP_LO) begin
      disp <= {{8{i_byte[7]}}, i_byte};  // RULE16
    end else if (take && state == S_DISP_HI) begin
      disp[15:8] <= i_byte;
    end else if (take && state == S_IMM_LO) begin
      imm <= {8'h00, i_byte};
    end else if (take && state == S_IMM_HI) begin
      imm[15:8] <= i_byte;
    end
  end

  // Count is sampled once so a moving source cannot skew the loop
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      count <= WORD_RESET;
    end else if (state == S_START) begin
      count <= iterate_prefix ? i_count_register : WORD_RESET;  // RULE13
    end else if (next_elem) begin
      count <= count - 16'd1;
    end
  end

  // ****************************************************************
  // Outputs straight from the working flops
  // ****************************************************************
  assign o_op             = op;
  assign o_word           = word;
  assign o_reg_is_dst     = reg_is_dst;
  assign o_operand_is_reg = is_reg;
  assign o_reg_field      = reg_field;
  assign o_rm_field       = rm_field;
  assign o_disp           = disp;
  assign o_imm            = imm;
  assign o_repeat         = iterate_prefix;
  assign o_count_left     = count;

endmodule

/* testbench/decoder_asserts.sv */
module decoder_asserts (
  input wire logic             i_mclk,
  input wire logic             i_reset,
  input wire logic             o_byte_ready,
  input wire logic             o_busy,
  input wire decoder_pkg::op_t o_op,
  input wire logic             o_word,
  input wire logic             o_operand_is_reg,
  input wire logic             o_repeat,
  input wire logic             o_element_strobe,
  input wire logic             o_done
);
  import decoder_pkg::*;
  // ****************************************************************
  // Execution budgets, counted from the start cycle
  // ****************************************************************
  logic prev_rdy;
  // Ready falling while busy marks the start cycle of an unprefixed op
  always_ff @(posedge i_mclk) prev_rdy <= o_byte_ready & ~i_reset;
  wire st = prev_rdy && !o_byte_ready && o_busy && !o_repeat;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  a_copy_budget: assert property (st && o_op == OP_STRING_COPY |-> ##15 o_done)
    else $error("copy budget wrong");
  a_compare_budget: assert property (st && o_op == OP_STRING_COMPARE |-> ##23 o_done)
    else $error("compare budget wrong");
  a_scan_budget: assert property (st && o_op == OP_STRING_SCAN |-> ##16 o_done)
    else $error("scan budget wrong");
  a_load_budget: assert property (st && o_op == OP_STRING_LOAD |-> ##13 o_done)
    else $error("load budget wrong");
  a_save_budget: assert property (st && o_op == OP_STRING_SAVE |-> ##11 o_done)
    else $error("save budget wrong");
  a_port_budget: assert property (st && o_op inside {OP_STRING_INPUT, OP_STRING_OUTPUT}
    |-> ##15 o_done) else $error("port budget wrong");
  a_acc_byte: assert property (st && o_op == OP_TEST_IMM_ACC && !o_word
    |-> !o_done [*4] ##1 o_done) else $error("byte acc budget wrong");
  a_acc_word: assert property (st && o_op == OP_TEST_IMM_ACC && o_word
    |-> !o_done [*5] ##1 o_done) else $error("word acc budget wrong");
  a_call_reg: assert property (st && o_op == OP_CALL_NEAR_IND && o_operand_is_reg
    |-> ##18 o_done) else $error("call budget wrong");
  a_strobe_repeat: assert property (o_element_strobe |-> o_repeat)
    else $error("element strobe without prefix");
endmodule

bind logic_string_call_decoder decoder_asserts chk (.i_mclk, .i_reset, .o_byte_ready, .o_busy,
  .o_op, .o_word, .o_operand_is_reg, .o_repeat, .o_element_strobe, .o_done);

/* testbench/fetch_feeder.sv */
module fetch_feeder (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_ready,
  input  wire logic       i_stall,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic       took;
  initial begin
    o_valid = 1'h0;
    o_byte = 8'h00;
  end
  // Take decision at the edge, update just after it; idle bus toggles
  always @(posedge i_mclk) begin
    took = o_valid && i_ready;
    #1;
    if (i_reset) q.delete();
    else if (took) void'(q.pop_front());
    o_valid = q.size() > 0 && !i_stall && !i_reset;
    o_byte = o_valid ? q[0] : ~o_byte;
  end
endmodule

/* testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import decoder_pkg::*;
  logic        i_mclk = 1'h0;
  logic        i_reset = 1'h1;
  logic        stall = 1'h0;
  logic        zf = 1'h0;
  logic [15:0] cnt = 16'h0000;
  logic [7:0]  fb;
  logic        fv, rdy, busy, wd, dst, isreg, iterate_prefix, stb, done, unc;
  op_t         op;
  logic [15:0] disp, imm, cl;
  logic [2:0]  rf, rmf;
  int          err_total = 0;
  int          cmp_count = 0;
  always #50 i_mclk = ~i_mclk;
  fetch_feeder feed (.i_mclk, .i_reset, .i_ready(rdy), .i_stall(stall), .o_valid(fv),
    .o_byte(fb));
  logic_string_call_decoder dut (.i_mclk, .i_reset, .i_byte_valid(fv), .i_byte(fb),
    .i_count_register(cnt), .i_zero_flag(zf), .o_byte_ready(rdy), .o_busy(busy), .o_op(op),
    .o_word(wd), .o_reg_is_dst(dst), .o_operand_is_reg(isreg), .o_reg_field(rf),
    .o_rm_field(rmf), .o_disp(disp), .o_imm(imm), .o_repeat(iterate_prefix), .o_count_left(cl),
    .o_element_strobe(stb),
    .o_done(done), .o_unclaimed(unc));
  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Counts start plus budget cycles, so a correct op shows cost + 1
  task automatic run(input logic [7:0] b[$], input int cost, input int n, input bit slow = 0);
    int cyc = 0;
    int ns = 0;
    int k = 0;
    foreach (b[i]) feed.q.push_back(b[i]);
    do begin
      stall = slow && k < 4;
      @(posedge i_mclk);
      #1;
      k++;
      if (busy === 1'h1 && rdy === 1'h0) cyc++;
      if (stb === 1'h1) ns++;
    end while (done !== 1'h1 && k < 600);
    if (k == 600) begin
      err_total++;
      conclude();
    end
    chk("cycles", 16'(cost + 1), 16'(cyc));
    chk("elements", 16'(n), 16'(ns));
  endtask
  task automatic refuse(input logic [7:0] b[$]);
    int k = 0;
    foreach (b[i]) feed.q.push_back(b[i]);
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (unc !== 1'h1 && k < 50);
    if (k == 50) begin
      err_total++;
      conclude();
    end
    chk("idle after refusal", 16'h0000, 16'(busy));
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic logic_forms;
    run('{8'h84, 8'hC0}, 3, 0, 1);
    chk("op", 16'(OP_TEST_RM), 16'(op));
    chk("is reg", 16'h0001, 16'(isreg));
    chk("word", 16'h0000, 16'(wd));
    run('{8'h85, 8'h06, 8'h34, 8'h12}, 10, 0);
    chk("disp", 16'h1234, disp);
    chk("word", 16'h0001, 16'(wd));
    run('{8'hF7, 8'h46, 8'h80, 8'hCD, 8'hAB}, 10, 0);
    chk("disp", 16'hFF80, disp);
    chk("imm", 16'hABCD, imm);
    run('{8'hF6, 8'hC3, 8'h5A}, 4, 0);
    chk("imm", 16'h005A, imm);
    run('{8'hA8, 8'h11}, 3, 0);
    run('{8'hA9, 8'h22, 8'h33}, 4, 0);
    chk("imm", 16'h3322, imm);
  endtask
  task automatic or_xor_not;
    run('{8'h0A, 8'hC1}, 3, 0);
    chk("op", 16'(OP_OR), 16'(op));
    chk("dst", 16'h0001, 16'(dst));
    run('{8'h09, 8'h07}, 10, 0);
    chk("dst", 16'h0000, 16'(dst));
    chk("is reg", 16'h0000, 16'(isreg));
    run('{8'h33, 8'hD8}, 3, 0);
    chk("op", 16'(OP_XOR), 16'(op));
    chk("reg field", 16'h0003, 16'(rf));
    chk("rm field", 16'h0000, 16'(rmf));
    run('{8'hF6, 8'hD0}, 3, 0);
    chk("op", 16'(OP_NOT), 16'(op));
    run('{8'hF7, 8'h17}, 10, 0);
  endtask
  task automatic strings_single;
    logic [7:0] opc[7] = '{8'hA4, 8'hA7, 8'hAE, 8'hAD, 8'hAA, 8'h6C, 8'h6F};
    int         cost[7] = '{14, 22, 15, 12, 10, 14, 14};
    op_t        ops[7] = '{OP_STRING_COPY, OP_STRING_COMPARE, OP_STRING_SCAN, OP_STRING_LOAD,
                           OP_STRING_SAVE, OP_STRING_INPUT, OP_STRING_OUTPUT};
    for (int i = 0; i < 7; i++) begin
      run('{opc[i]}, cost[i], 0);
      chk("op", 16'(ops[i]), 16'(op));
      chk("word", 16'(opc[i][0]), 16'(wd));
    end
  endtask
  task automatic strings_repeat;
    cnt = 16'h0003;
    run('{8'hF2, 8'hA4}, 8 + 8 * 3, 3);
    chk("repeat", 16'h0001, 16'(iterate_prefix));
    cnt = 16'h0000;
    run('{8'hF2, 8'hAD}, 6, 0);
    cnt = 16'h0004;
    run('{8'hF3, 8'hA6}, 5 + 22, 1);
    chk("count left", 16'h0003, cl);
    zf = 1'h1;
    cnt = 16'h0002;
    run('{8'hF3, 8'hA6}, 5 + 22 * 2, 2);
    chk("count left", 16'h0000, cl);
    zf = 1'h0;
    cnt = 16'h0002;
    run('{8'hF2, 8'hAF}, 5 + 15 * 2, 2);
    run('{8'hF2, 8'hAB}, 6 + 9 * 2, 2);
    run('{8'hF2, 8'h6D}, 8 + 8 * 2, 2);
  endtask
  task automatic call_refuse;
    run('{8'hFF, 8'hD3}, 17, 0);
    chk("op", 16'(OP_CALL_NEAR_IND), 16'(op));
    run('{8'hFF, 8'h16, 8'h00, 8'h20}, 27, 0);
    refuse('{8'hF6, 8'hC8});
    refuse('{8'hF3, 8'hA4});
    run('{8'h84, 8'hC0}, 3, 0);
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    #1;
    chk("ready in reset", 16'h0000, 16'(rdy));
    chk("op in reset", 16'(OP_NONE), 16'(op));
    i_reset = 1'h0;
    @(posedge i_mclk);
    #1;
    logic_forms();
    or_xor_not();
    strings_single();
    strings_repeat();
    call_refuse();
    conclude();
  end
endmodule
